// ===== core/gfci_selftest_pkg.sv
// Purpose: Constants and types for the GFCI periodic self-test sequencer
// Assumes: 25 MHz system clock
// Notes: Long counts are overridable parameters in the top module
package gfci_selftest_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_DIV = (CLK_HZ / 1000000) * TICK_US;
    localparam int unsigned FIRST_DELAY_MS = 1016;
    localparam int unsigned PERIOD_MIN = 90;
    localparam int unsigned PERIOD_MS = PERIOD_MIN * 60 * 1000;
    localparam int unsigned TEST_TIMEOUT_MS = 66;
    localparam int unsigned PHASE_TIMEOUT_MS = 60;
    localparam int unsigned ALARM_FREQ_MHZ = 3750;
    localparam int unsigned ALARM_HALF_MS = 500000 / ALARM_FREQ_MHZ;
    localparam int unsigned MS_W = 23;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAIT_POS = 3'b001,
        ST_POS = 3'b010,
        ST_FIRE = 3'b011,
        ST_EOL = 3'b100
    } seq_state_t;

    typedef struct packed {
        logic bias;
        logic fault_sim;
        logic alarm;
    } drive_t;
endpackage : gfci_selftest_pkg

// ===== core/gfci_periodic_self_test_seq.sv
// Purpose: Self-test sequencer for a GFCI controller companion
// Assumes: Inputs synchronous to mclk_i; rst_i is the power-on reset pulse
// Notes: One shared millisecond tick drives every timer
`timescale 1ns/1ps
`default_nettype none
module gfci_periodic_self_test_seq #(
    parameter int unsigned TICK_DIV = gfci_selftest_pkg::TICK_DIV,
    parameter int unsigned FIRST_MS = gfci_selftest_pkg::FIRST_DELAY_MS,
    parameter int unsigned PERIOD_MS = gfci_selftest_pkg::PERIOD_MS,
    parameter int unsigned TIMEOUT_MS = gfci_selftest_pkg::TEST_TIMEOUT_MS,
    parameter int unsigned PHASE_MS = gfci_selftest_pkg::PHASE_TIMEOUT_MS,
    parameter int unsigned ALARM_HALF_MS = gfci_selftest_pkg::ALARM_HALF_MS
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic phase_pos_i,
    input wire logic phase_near_end_i,
    input wire logic anode_sense_in,
    input wire logic anode_low_i,
    output logic bias_en_o,
    output logic fault_sim_o,
    output logic end_of_life_alarm_out,
    output logic test_active_o,
    output logic test_pass_o
);
    localparam int MW = gfci_selftest_pkg::MS_W;
    localparam logic [MW-1:0] FIRST_C = MW'(FIRST_MS - 1);
    localparam logic [MW-1:0] PERIOD_C = MW'(PERIOD_MS - 1);
    localparam logic [MW-1:0] TOUT_C = MW'(TIMEOUT_MS - 1);
    localparam logic [MW-1:0] PHASE_C = MW'(PHASE_MS - 1);
    localparam logic [MW-1:0] HALF_C = MW'(ALARM_HALF_MS - 1);

    gfci_selftest_pkg::seq_state_t state_r, state_nxt;
    gfci_selftest_pkg::drive_t drv_r, drv_nxt;
    logic [31:0] div_r;
    logic tick_r;
    logic [MW-1:0] wait_r, tout_r, phase_ms_r, alarm_ms_r;
    logic waiting_r, phase_ok_r, phase_done_r, cont_r, trig_r, phase_d_r;

    // Shared millisecond timebase
    wire div_end = (div_r == TICK_DIV - 1);
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            div_r <= 32'h0;
            tick_r <= 1'b0;
        end else begin
            div_r <= div_end ? 32'h0 : div_r + 32'h1;
            tick_r <= div_end;
        end
    end

    wire phase_rise = phase_pos_i && !phase_d_r;
    wire phase_fall = !phase_pos_i && phase_d_r;
    wire in_test = (state_r == gfci_selftest_pkg::ST_WAIT_POS) || (state_r == gfci_selftest_pkg::ST_POS)
        || (state_r == gfci_selftest_pkg::ST_FIRE);
    wire cont_set = (state_r == gfci_selftest_pkg::ST_POS) && phase_pos_i && anode_sense_in;
    wire trig_set = (state_r == gfci_selftest_pkg::ST_FIRE) && anode_low_i;
    wire cycle_pass = (cont_r || cont_set) && trig_set;
    wire wait_done = waiting_r && tick_r && (wait_r == 0);
    wire tout_hit = in_test && tick_r && (tout_r == TOUT_C);
    wire phase_fail = !phase_done_r && !phase_ok_r && tick_r && (phase_ms_r == PHASE_C);
    // New cycle clears the last verdict
    wire test_start = (state_r == gfci_selftest_pkg::ST_IDLE) && wait_done;

    // Delay, periodic, timeout and phase timers
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_r <= FIRST_C;
            waiting_r <= 1'b1;
            tout_r <= '0;
            phase_ms_r <= '0;
            phase_ok_r <= 1'b0;
            phase_done_r <= 1'b0;
            phase_d_r <= 1'b0;
        end else begin
            phase_d_r <= phase_pos_i;
            if (phase_rise || phase_fall) begin
                phase_ok_r <= 1'b1;
            end
            if (tick_r && !phase_done_r) begin
                phase_ms_r <= phase_ms_r + MW'(1);
                if (phase_ms_r == PHASE_C) begin
                    phase_done_r <= 1'b1;
                end
            end
            if (cycle_pass) begin
                wait_r <= PERIOD_C;
                waiting_r <= 1'b1;
            end else if (wait_done) begin
                waiting_r <= 1'b0;
            end else if (waiting_r && tick_r) begin
                wait_r <= wait_r - MW'(1);
            end
            if (!in_test) begin
                tout_r <= '0;
            end else if (tick_r) begin
                tout_r <= tout_r + MW'(1);
            end
        end
    end

    // Sequencer
    always_comb begin
        state_nxt = state_r;
        drv_nxt = drv_r;
        case (state_r)
            gfci_selftest_pkg::ST_IDLE: begin
                drv_nxt = '0;
                if (wait_done) begin
                    state_nxt = gfci_selftest_pkg::ST_WAIT_POS;
                end
            end
            gfci_selftest_pkg::ST_WAIT_POS: begin
                if (phase_rise) begin
                    state_nxt = gfci_selftest_pkg::ST_POS;
                end
            end
            gfci_selftest_pkg::ST_POS: begin
                if (phase_near_end_i) begin
                    drv_nxt.bias = 1'b1;
                end
                if (phase_fall) begin
                    drv_nxt.fault_sim = 1'b1;
                    state_nxt = gfci_selftest_pkg::ST_FIRE;
                end
            end
            gfci_selftest_pkg::ST_FIRE: begin
                if (trig_set) begin
                    drv_nxt.bias = 1'b0;
                    drv_nxt.fault_sim = 1'b0;
                    state_nxt = cycle_pass ? gfci_selftest_pkg::ST_IDLE : gfci_selftest_pkg::ST_WAIT_POS;
                end else if (phase_rise) begin
                    drv_nxt.bias = 1'b0;
                    drv_nxt.fault_sim = 1'b0;
                    state_nxt = gfci_selftest_pkg::ST_POS;
                end
            end
            gfci_selftest_pkg::ST_EOL: begin
                drv_nxt.bias = 1'b0;
                drv_nxt.fault_sim = 1'b0;
                if (tick_r && alarm_ms_r == HALF_C) begin
                    drv_nxt.alarm = !drv_r.alarm;
                end
            end
            default: begin
                state_nxt = gfci_selftest_pkg::ST_IDLE;
                drv_nxt = '0;
            end
        endcase
        if (state_r != gfci_selftest_pkg::ST_EOL && (tout_hit || phase_fail)) begin
            state_nxt = gfci_selftest_pkg::ST_EOL;
            drv_nxt = '{bias: 1'b0, fault_sim: 1'b0, alarm: 1'b1};
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= gfci_selftest_pkg::ST_IDLE;
            drv_r <= '0;
            cont_r <= 1'b0;
            trig_r <= 1'b0;
            alarm_ms_r <= '0;
            test_pass_o <= 1'b0;
        end else begin
            state_r <= state_nxt;
            drv_r <= drv_nxt;
            if (!in_test) begin
                cont_r <= 1'b0;
                trig_r <= 1'b0;
            end else begin
                cont_r <= cont_r | cont_set;
                trig_r <= trig_r | trig_set;
            end
            if (state_r != gfci_selftest_pkg::ST_EOL) begin
                alarm_ms_r <= '0;
            end else if (tick_r) begin
                alarm_ms_r <= (alarm_ms_r == HALF_C) ? '0 : alarm_ms_r + MW'(1);
            end
            if (cycle_pass) begin
                test_pass_o <= 1'b1;
            end else if (test_start) begin
                test_pass_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            bias_en_o <= 1'b0;
            fault_sim_o <= 1'b0;
            end_of_life_alarm_out <= 1'b0;
            test_active_o <= 1'b0;
        end else begin
            bias_en_o <= drv_nxt.bias;
            fault_sim_o <= drv_nxt.fault_sim;
            end_of_life_alarm_out <= drv_nxt.alarm;
            test_active_o <= (state_nxt != gfci_selftest_pkg::ST_IDLE) && (state_nxt != gfci_selftest_pkg::ST_EOL);
        end
    end

    a_trig_drops_drive: assert property (@(posedge mclk_i) disable iff (rst_i)
        trig_set |=> !fault_sim_o && !bias_en_o) else $error("drive not released on trigger");
    a_fault_on_fall: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state_r == gfci_selftest_pkg::ST_POS && phase_fall && !tout_hit && !phase_fail) |=> fault_sim_o)
        else $error("fault pulse missing at half cycle end");
    a_bias_near_end: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state_r == gfci_selftest_pkg::ST_POS && phase_near_end_i && !tout_hit && !phase_fail) |=> bias_en_o)
        else $error("bias not enabled near end");
    a_end_of_life_alarm_out_high: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state_r != gfci_selftest_pkg::ST_EOL && tout_hit) |=> end_of_life_alarm_out && state_r == gfci_selftest_pkg::ST_EOL)
        else $error("timeout did not latch end of life");
    a_phase_fail_eol: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state_r != gfci_selftest_pkg::ST_EOL && phase_fail) |=> end_of_life_alarm_out)
        else $error("phase timeout did not alarm");
    a_eol_no_drive: assert property (@(posedge mclk_i) disable iff (rst_i)
        state_r == gfci_selftest_pkg::ST_EOL |-> !fault_sim_o && !bias_en_o) else $error("drive during end of life");
    a_pass_rearms: assert property (@(posedge mclk_i) disable iff (rst_i)
        cycle_pass |=> waiting_r && wait_r == PERIOD_C && test_pass_o) else $error("pass did not rearm period");
    a_first_start: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state_r == gfci_selftest_pkg::ST_IDLE && wait_done && !phase_fail) |=> state_r == gfci_selftest_pkg::ST_WAIT_POS)
        else $error("test did not start after delay");
    a_pass_needs_both: assert property (@(posedge mclk_i) disable iff (rst_i)
        $rose(test_pass_o) |-> $past(trig_set) && $past(cont_r || cont_set)) else $error("pass without both checks");
endmodule : gfci_periodic_self_test_seq
`default_nettype wire

// ===== test/line_partner.sv
// Purpose: Line side model: phase sense, anode comparator and rectifier
// Assumes: Line cycle of 2*HALF clocks, positive half first
// Notes: Rectifier fires only while fault drive and bias are both on
`timescale 1ns/1ps
`default_nettype none
module line_partner #(
    parameter int unsigned HALF = 8
) (
    input wire logic mclk_i,
    input wire logic run_i,
    input wire logic cont_ok_i,
    input wire logic fire_ok_i,
    input wire logic fault_sim_i,
    input wire logic bias_en_i,
    output logic phase_pos_o,
    output logic near_end_o,
    output logic anode_sense_o,
    output logic anode_low_o
);
    logic [4:0] cnt_r = 5'h00;
    logic fire_r = 1'b0;
    assign phase_pos_o = run_i && (cnt_r < 5'(HALF));
    assign near_end_o = phase_pos_o && (cnt_r >= 5'(HALF - 2));
    assign anode_sense_o = phase_pos_o && cont_ok_i && (cnt_r >= 5'h02) && (cnt_r < 5'h06);
    assign anode_low_o = fire_r;
    always_ff @(posedge mclk_i) begin
        cnt_r <= (cnt_r == 5'(2 * HALF - 1)) ? 5'h00 : cnt_r + 5'h01;
        fire_r <= fire_ok_i && fault_sim_i && bias_en_i;
    end
endmodule : line_partner
`default_nettype wire

// ===== test/gfci_periodic_self_test_seq_test.sv
// Purpose: Self-checking bench for the self-test sequencer
// Assumes: Shortened timers except the test timeout, one millisecond tick is 10 clocks
// Notes: Line partner supplies phase and anode signals
`timescale 1ns/1ps
`default_nettype none
module gfci_periodic_self_test_seq_test;
    localparam int MS = 10;
    localparam int TO = gfci_selftest_pkg::TEST_TIMEOUT_MS * MS;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic run = 1'b1;
    logic cont_ok = 1'b1;
    logic fire_ok = 1'b1;
    logic phase_pos, near_end, anode_sense, anode_low;
    logic bias_en, fault_sim, alarm, active, pass;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    int i;

    line_partner line_partner_inst (.mclk_i(mclk_i), .run_i(run), .cont_ok_i(cont_ok), .fire_ok_i(fire_ok),
        .fault_sim_i(fault_sim), .bias_en_i(bias_en), .phase_pos_o(phase_pos), .near_end_o(near_end),
        .anode_sense_o(anode_sense), .anode_low_o(anode_low));
    gfci_periodic_self_test_seq #(.TICK_DIV(MS), .FIRST_MS(3), .PERIOD_MS(20), .PHASE_MS(6),
        .ALARM_HALF_MS(2)) gfci_periodic_self_test_seq_inst (.mclk_i(mclk_i), .rst_i(rst_i),
        .phase_pos_i(phase_pos), .phase_near_end_i(near_end), .anode_sense_in(anode_sense),
        .anode_low_i(anode_low), .bias_en_o(bias_en), .fault_sim_o(fault_sim),
        .end_of_life_alarm_out(alarm), .test_active_o(active), .test_pass_o(pass));

    initial begin
        forever #20 mclk_i = ~mclk_i;
    end

    task automatic final_report;
        $display("Checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails = fails + 1;
            final_report();
        end
    end

    task automatic check(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : tick

    task automatic do_reset(input logic r, input logic c, input logic f);
        @(posedge mclk_i);
        rst_i <= 1'b1;
        run <= r;
        cont_ok <= c;
        fire_ok <= f;
        tick(10);
        check("outputs in reset", 1'b0, |{bias_en, fault_sim, alarm, active, pass});
        @(posedge mclk_i);
        rst_i <= 1'b0;
        tick(2);
        check("outputs after reset", 1'b0, |{bias_en, fault_sim, alarm, active, pass});
    endtask : do_reset

    task automatic phase_stuck;
        do_reset(1'b0, 1'b1, 1'b1);
        tick(4 * MS);
        check("alarm before phase timeout", 1'b0, alarm);
        for (i = 0; i < 4 * MS && alarm !== 1'b1; i++) tick(1);
        check("alarm at phase timeout", 1'b1, alarm);
    endtask : phase_stuck

    task automatic pass_cycle;
        do_reset(1'b1, 1'b1, 1'b1);
        tick(2 * MS);
        check("active before delay", 1'b0, active);
        for (i = 0; i < 2 * MS && active !== 1'b1; i++) tick(1);
        check("active after delay", 1'b1, active);
        for (i = 0; i < 40 && bias_en !== 1'b1; i++) tick(1);
        check("bias in positive half", 1'b1, bias_en & phase_pos & ~fault_sim);
        for (i = 0; i < 8 && fault_sim !== 1'b1; i++) tick(1);
        check("fault drive after fall", 1'b1, fault_sim & ~phase_pos & bias_en);
        tick(3);
        check("drive released", 1'b0, bias_en | fault_sim);
        check("cycle passed", 1'b1, pass & ~active & ~alarm);
        tick(15 * MS);
        check("idle before period", 1'b0, active);
        for (i = 0; i < 7 * MS && active !== 1'b1; i++) tick(1);
        check("periodic restart", 1'b1, active);
        check("pass cleared on restart", 1'b0, pass);
    endtask : pass_cycle

    task automatic fail_cycle(input logic c, input logic f);
        do_reset(1'b1, c, f);
        for (i = 0; i < 5 * MS && active !== 1'b1; i++) tick(1);
        tick(TO - 1);
        check("alarm before test timeout", 1'b0, alarm);
        tick(1);
        check("alarm after test timeout", 1'b1, alarm & ~pass);
        for (i = 0; i < 40 && alarm === 1'b1; i++) tick(1);
        check("alarm half period", 1'b1, i == 2 * MS);
    endtask : fail_cycle

    initial begin
        phase_stuck();
        pass_cycle();
        fail_cycle(1'b1, 1'b0);
        fail_cycle(1'b0, 1'b1);
        final_report();
    end
endmodule : gfci_periodic_self_test_seq_test
`default_nettype wire
